// ---- stx_exec.sv ----
// Execution unit for zero-test skips, table reads and exclusive-OR operations
//
// Operation
// - Skip next when memory byte is zero
// - Taken skip inserts one dummy cycle
// - Copy byte to working register, skip if zero
// - Skip next when selected bit is zero
// - Current-page table read, low/high split
// - High pointer enabled forms full table address
// - Last-page table read, low/high split
// - XOR memory into working register, zero flag
// - XOR result written back to memory
// - XOR immediate into working register, zero flag
`timescale 1ns/1ps

module stx_exec #(
  parameter int unsigned PAGE_W = 8
) (
  // Clock, reset, enable
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  // Instruction from decoder
  input  wire logic                        instr_valid,
  input  wire stx_pkg::stx_op_t            instr_op,
  input  wire logic [stx_pkg::DATA_W-1:0]  instr_imm,
  input  wire logic [stx_pkg::BIT_SEL_W-1:0] instr_bit,
  input  wire logic [stx_pkg::DATA_W-1:0]  mem_rdata,
  output logic                             instr_ready,
  // Table pointers and mode
  input  wire logic [7:0]                  table_pointer_low,
  input  wire logic [7:0]                  table_pointer_high,
  input  wire logic                        table_high_enable,
  input  wire logic [stx_pkg::PADDR_W-1:0] current_pc,
  // Program memory read port
  output logic                             prog_rd_en,
  output logic [stx_pkg::PADDR_W-1:0]      prog_addr,
  input  wire logic [stx_pkg::PROG_W-1:0]  prog_rdata,
  // Data memory write port
  output logic                             mem_we,
  output logic [stx_pkg::DATA_W-1:0]       mem_wdata,
  // Core state
  output logic [stx_pkg::DATA_W-1:0]       working_register,
  output logic [stx_pkg::DATA_W-1:0]       table_high_latch,
  output logic                             zero_flag,
  output logic                             skip_next,
  output logic                             dummy_cycle
);
  import stx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Constants

  // In-page bits of a program address; the bits above them pick the page
  localparam logic [PADDR_W-1:0] IN_PAGE_MASK = PADDR_W'((1 << PAGE_W) - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  stx_state_t                st_q;
  stx_state_t                st_d;
  logic                      skip_q;
  logic                      skip_d;

  // Working register and zero flag
  logic [DATA_W-1:0]         wreg_q;
  logic [DATA_W-1:0]         wreg_d;
  logic                      z_q;
  logic                      z_d;

  // Data memory write
  logic                      we_q;
  logic                      we_d;
  logic [DATA_W-1:0]         wd_q;
  logic [DATA_W-1:0]         wd_d;

  // Table read
  logic [PADDR_W-1:0]        pa_q;
  logic [PADDR_W-1:0]        pa_d;
  logic                      prd_q;
  logic                      prd_d;
  logic [DATA_W-1:0]         tbh_q;
  logic [DATA_W-1:0]         tbh_d;

  // Decode
  logic                      take;
  logic                      op_skip_zero;
  logic                      op_copy_skip;
  logic                      op_skip_bit;
  logic                      op_table_cur;
  logic                      op_table_last;
  logic                      op_xor_work;
  logic                      op_xor_mem;
  logic                      op_xor_imm;

  // Operand tests and results
  logic                      byte_zero;
  logic [DATA_W-1:0]         bit_sel;
  logic [DATA_W-1:0]         bit_clear;
  logic                      bit_zero;
  logic                      skip_hit;
  logic                      table_go;
  logic [DATA_W-1:0]         xor_mem;
  logic [DATA_W-1:0]         xor_imm;
  logic [PADDR_W-1:0]        page_hi;
  logic [PADDR_W-1:0]        table_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode

  // Busy cycles refuse a new instruction with instr_ready low; the decoder must hold it
  assign take = instr_valid && (st_q == STX_IDLE);

  always_comb begin
    op_skip_zero  = 1'b0;
    op_copy_skip  = 1'b0;
    op_skip_bit   = 1'b0;
    op_table_cur  = 1'b0;
    op_table_last = 1'b0;
    op_xor_work   = 1'b0;
    op_xor_mem    = 1'b0;
    op_xor_imm    = 1'b0;
    case (instr_op)
      STX_OP_SKIP_IF_ZERO: begin
        op_skip_zero = 1'b1;
      end
      STX_OP_COPY_SKIP_IF_ZERO: begin
        op_copy_skip = 1'b1;
      end
      STX_OP_SKIP_IF_BIT_ZERO: begin
        op_skip_bit = 1'b1;
      end
      STX_OP_TABLE_READ_CURRENT_PAGE: begin
        op_table_cur = 1'b1;
      end
      STX_OP_TABLE_READ_LAST_PAGE: begin
        op_table_last = 1'b1;
      end
      STX_OP_XOR_TO_WORK: begin
        op_xor_work = 1'b1;
      end
      STX_OP_EXCLUSIVE_OR_TO_MEMORY: begin
        op_xor_mem = 1'b1;
      end
      STX_OP_XOR_IMMEDIATE: begin
        op_xor_imm = 1'b1;
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand tests

  assign byte_zero = (mem_rdata == ZERO_BYTE);

  // One selector and one zero test per data bit
  for (genvar gi = 0; gi < DATA_W; gi++) begin : g_bit_test
    assign bit_sel[gi]   = (instr_bit == BIT_SEL_W'(gi));
    assign bit_clear[gi] = bit_sel[gi] && !mem_rdata[gi];
  end

  assign bit_zero = |bit_clear;

  // Every skip whose test passes, in the cycle it is taken
  assign skip_hit = take && (((op_skip_zero || op_copy_skip) && byte_zero) ||
                             (op_skip_bit && bit_zero));

  assign table_go = take && (op_table_cur || op_table_last);

  assign xor_mem = wreg_q ^ mem_rdata;
  assign xor_imm = wreg_q ^ instr_imm;

  ////////////////////////////////////////////////////////////////////////////
  // Table address

  // Current page keeps the page bits of the program counter
  assign page_hi = current_pc & ~IN_PAGE_MASK;

  always_comb begin
    if (op_table_last) begin
      // Last page: every page bit high
      table_addr = ~IN_PAGE_MASK | PADDR_W'(table_pointer_low);
    end else if (table_high_enable) begin
      // High pointer bits above the program address width are dropped
      table_addr = PADDR_W'({table_pointer_high, table_pointer_low});
    end else begin
      table_addr = page_hi | PADDR_W'(table_pointer_low);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    st_d   = st_q;
    skip_d = 1'b0;
    case (st_q)
      STX_IDLE: begin
        if (skip_hit) begin
          skip_d = 1'b1;
          st_d   = STX_DUMMY;
        end else if (table_go) begin
          st_d   = STX_TABLE_FETCH;
        end
      end
      STX_TABLE_FETCH: begin
        st_d = STX_IDLE;
      end
      STX_DUMMY: begin
        // Holds off the next instruction while the skipped one is fetched
        st_d = STX_IDLE;
      end
      default: begin
        st_d = STX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q   <= STX_IDLE;
      skip_q <= 1'b0;
    end else if (clk_en) begin
      st_q   <= st_d;
      skip_q <= skip_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register and zero flag

  always_comb begin
    wreg_d = wreg_q;
    z_d    = z_q;
    if (take && op_copy_skip) begin
      // Copy only; flags stay as they are
      wreg_d = mem_rdata;
    end else if (take && op_xor_work) begin
      wreg_d = xor_mem;
      z_d    = (xor_mem == ZERO_BYTE);
    end else if (take && op_xor_mem) begin
      z_d    = (xor_mem == ZERO_BYTE);
    end else if (take && op_xor_imm) begin
      wreg_d = xor_imm;
      z_d    = (xor_imm == ZERO_BYTE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wreg_q <= RESET_BYTE;
      z_q    <= RESET_FLAG;
    end else if (clk_en) begin
      wreg_q <= wreg_d;
      z_q    <= z_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory write

  always_comb begin
    we_d = 1'b0;
    wd_d = wd_q;
    if (take && op_xor_mem) begin
      we_d = 1'b1;
      wd_d = xor_mem;
    end else if (st_q == STX_TABLE_FETCH) begin
      // Program word is read in the same cycle its address is out on prog_addr
      we_d = 1'b1;
      wd_d = prog_rdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      we_q <= 1'b0;
      wd_q <= RESET_BYTE;
    end else if (clk_en) begin
      we_q <= we_d;
      wd_q <= wd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table read

  always_comb begin
    pa_d  = pa_q;
    prd_d = 1'b0;
    tbh_d = tbh_q;
    if (table_go) begin
      pa_d  = table_addr;
      prd_d = 1'b1;
    end
    if (st_q == STX_TABLE_FETCH) begin
      tbh_d = prog_rdata[PROG_W-1:DATA_W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pa_q  <= RESET_ADDR;
      prd_q <= 1'b0;
      tbh_q <= RESET_BYTE;
    end else if (clk_en) begin
      pa_q  <= pa_d;
      prd_q <= prd_d;
      tbh_q <= tbh_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // New instruction accepted only in idle; non-skipping skips take one cycle
  assign instr_ready      = (st_q == STX_IDLE);
  assign prog_rd_en       = prd_q;
  assign prog_addr        = pa_q;
  assign mem_we           = we_q;
  assign mem_wdata        = wd_q;
  assign working_register = wreg_q;
  assign table_high_latch = tbh_q;
  assign zero_flag        = z_q;
  assign skip_next        = skip_q;
  assign dummy_cycle      = (st_q == STX_DUMMY);

endmodule : stx_exec

// ---- stx_exec_props.sv ----
// Checker for the skip, table and exclusive-OR execution unit
`timescale 1ns/1ps
module stx_exec_props import stx_pkg::*; (
  // Control and handshake
  input wire logic       ref_clk, reset, clk_en, instr_valid, instr_ready, prog_rd_en,
  input wire logic       mem_we, zero_flag, skip_next, dummy_cycle,
  input wire stx_op_t    instr_op,
  input wire logic [2:0] instr_bit,
  // Operands and results
  input wire logic [7:0] mem_rdata, instr_imm, mem_wdata, working_register
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire tk = clk_en && instr_valid && instr_ready;
  ////////////////////////////////////////////////////////////////////////////////
  property p_sz; tk && instr_op == STX_OP_SKIP_IF_ZERO && mem_rdata == 8'h00
    |=> skip_next && dummy_cycle; endproperty
  a_sz: assert property (p_sz) else $error("zero skip missed");
  property p_dum; skip_next |-> dummy_cycle && !instr_ready; endproperty
  a_dum: assert property (p_dum) else $error("no dummy cycle");
  property p_sza; tk && instr_op == STX_OP_COPY_SKIP_IF_ZERO
    |=> working_register == $past(mem_rdata) && $stable(zero_flag); endproperty
  a_sza: assert property (p_sza) else $error("copy skip wrong");
  property p_bit; tk && instr_op == STX_OP_SKIP_IF_BIT_ZERO && !mem_rdata[instr_bit]
    |=> skip_next; endproperty
  a_bit: assert property (p_bit) else $error("bit skip missed");
  property p_tbl; tk && (instr_op == STX_OP_TABLE_READ_CURRENT_PAGE
    || instr_op == STX_OP_TABLE_READ_LAST_PAGE) |=> prog_rd_en && !instr_ready ##1 mem_we;
  endproperty
  a_tbl: assert property (p_tbl) else $error("table read timing");
  property p_xw; tk && instr_op == STX_OP_XOR_TO_WORK |=> working_register ==
    ($past(working_register) ^ $past(mem_rdata)) && zero_flag == (working_register == 0);
  endproperty
  a_xw: assert property (p_xw) else $error("xor to work wrong");
  property p_xm; tk && instr_op == STX_OP_EXCLUSIVE_OR_TO_MEMORY |=> mem_we && mem_wdata ==
    ($past(working_register) ^ $past(mem_rdata)) && $stable(working_register); endproperty
  a_xm: assert property (p_xm) else $error("xor to memory wrong");
  property p_xi; tk && instr_op == STX_OP_XOR_IMMEDIATE |=> working_register ==
    ($past(working_register) ^ $past(instr_imm)); endproperty
  a_xi: assert property (p_xi) else $error("xor immediate wrong");
  property p_frz; !clk_en |=> $stable(working_register) && $stable(zero_flag)
    && $stable(skip_next) && $stable(mem_we) && $stable(dummy_cycle); endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
endmodule : stx_exec_props

bind stx_exec stx_exec_props u_props (.*);

// ---- stx_exec_tb.sv ----
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module stx_exec_tb;
  import stx_pkg::*;
  typedef struct packed {int c; logic [7:0] w, t, d; logic z, s, e;} stx_exp_t;
  logic ref_clk = 0, reset = 1, clk_en = 1, instr_valid = 0, table_high_enable = 0;
  logic instr_ready, prog_rd_en, mem_we, zero_flag, skip_next, dummy_cycle, z = 0, hung = 0;
  logic [7:0] instr_imm = 0, mem_rdata = 0, table_pointer_low = 0, table_pointer_high = 0;
  logic [7:0] mem_wdata, working_register, table_high_latch, w = 0, t = 0;
  logic [2:0] instr_bit = 0;
  logic [11:0] current_pc = 0, prog_addr;
  logic [15:0] prog_rdata;
  stx_op_t instr_op = STX_OP_NONE;
  int seed = 73, cyc = 0, k, miscompares = 0, num_checks = 0;
  stx_exp_t q[$];
  stx_exec dut (.*);
  // Word content tied to its address, so page bits show up in the low byte
  assign prog_rdata = {prog_addr[7:0] ^ 8'h3C, prog_addr[11:4]};
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task cmp(stx_exp_t x);
    num_checks++;
    if ({working_register, zero_flag, table_high_latch, skip_next, mem_we} !==
        {x.w, x.z, x.t, x.s, x.e} || (x.e && mem_wdata !== x.d)) begin
      miscompares++;
      $display("ERROR %0t result mismatch", $time);
    end
  endtask : cmp
  // Registered results are settled at the falling edge
  always @(negedge ref_clk) begin
    if (q.size() > 0 && q[0].c == cyc) cmp(q.pop_front());
  end
  task end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Drive one instruction and hold it until a ready edge takes it
  task issue(stx_op_t op);
    stx_exp_t x;
    logic [11:0] a;
    logic r;
    int n;
    k = $random(seed) & 3;
    instr_op = op;
    instr_valid = 1;
    mem_rdata = k == 0 ? 8'h00 : k == 1 ? w : 8'($random(seed));
    instr_imm = k == 1 ? w : 8'($random(seed));
    {instr_bit, table_pointer_low, table_pointer_high} = 19'($random(seed));
    {table_high_enable, current_pc} = 13'($random(seed));
    n = 0;
    do begin
      // Freeze an idle cycle now and then; busy cycles keep the enable high
      clk_en = !instr_ready || ($random(seed) & 7) != 0;
      r = instr_ready && clk_en;
      @(posedge ref_clk);
      #1;
      n++;
    end while (!r && n < 16);
    if (!r) begin
      miscompares++;
      hung = 1;
      return;
    end
    a = op == STX_OP_TABLE_READ_LAST_PAGE ? {4'hF, table_pointer_low} : table_high_enable ?
        {table_pointer_high[3:0], table_pointer_low} : {current_pc[11:8], table_pointer_low};
    x = '0;
    x.c = cyc;
    case (op)
      STX_OP_SKIP_IF_ZERO: x.s = mem_rdata == 8'h00;
      STX_OP_COPY_SKIP_IF_ZERO: begin w = mem_rdata; x.s = w == 8'h00; end
      STX_OP_SKIP_IF_BIT_ZERO: x.s = !mem_rdata[instr_bit];
      STX_OP_XOR_TO_WORK: begin w = w ^ mem_rdata; z = w == 8'h00; end
      STX_OP_XOR_IMMEDIATE: begin w = w ^ instr_imm; z = w == 8'h00; end
      STX_OP_EXCLUSIVE_OR_TO_MEMORY: begin x.e = 1; x.d = w ^ mem_rdata; z = x.d == 0; end
      default: begin x.c++; x.e = 1; x.d = a[11:4]; t = a[7:0] ^ 8'h3C; end
    endcase
    {x.w, x.z, x.t} = {w, z, t};
    q.push_back(x);
  endtask : issue
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 reset = 0;
    x_reset_note: q.push_back('{cyc, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0});
    for (int i = 0; i < 200 && !hung; i++)
      issue(stx_op_t'(i < 8 ? i + 1 : 1 + $unsigned($random(seed)) % 8));
    instr_valid = 0;
    repeat (4) @(posedge ref_clk);
    if (q.size() > 0) miscompares++;
    end_of_test;
  end
endmodule : stx_exec_tb

// ---- stx_pkg.sv ----
// Package: opcodes, widths and reset values for the skip/table/xor execution block
package stx_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PROG_W     = 16;
  localparam int unsigned PADDR_W    = 12;
  localparam int unsigned BIT_SEL_W  = 3;

  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  localparam logic       RESET_FLAG  = 1'b0;
  localparam logic [PADDR_W-1:0] RESET_ADDR = 12'h000;

  // Operation selector coming from the instruction decoder
  typedef enum logic [3:0] {
    STX_OP_NONE,
    STX_OP_SKIP_IF_ZERO,
    STX_OP_COPY_SKIP_IF_ZERO,
    STX_OP_SKIP_IF_BIT_ZERO,
    STX_OP_TABLE_READ_CURRENT_PAGE,
    STX_OP_TABLE_READ_LAST_PAGE,
    STX_OP_XOR_TO_WORK,
    STX_OP_EXCLUSIVE_OR_TO_MEMORY,
    STX_OP_XOR_IMMEDIATE
  } stx_op_t;

  typedef enum logic [1:0] {
    STX_IDLE,
    STX_TABLE_FETCH,
    STX_DUMMY
  } stx_state_t;

endpackage : stx_pkg
